// *** rtl/chsel_device.sv ***
// Function
// - Open or high mode selects serial mode
// - Pin one clocks, pin two carries data
// - Shift channel number, latch, then select it
// - Both lines high after eighth bit latches
// - Host holds clock high eight microseconds
// - Host holds clock low five microseconds
// - Latch condition held five microseconds
// - Packet lasts at least 157 microseconds
// - Host idles before and between packets
// - Packet starts data low, clock falls
// - No upper time limit on loading
// - Power-up in serial selects channel 50
// - Bad load falls back to channel 0
// - Host leaves default within 200 microseconds
// - Host avoids default channel for traffic
// - Grounded mode uses three parallel pins
// - New channel settled within 1.5 ms
// - Ready within 10 ms of power
module chsel_device
  import chsel_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC,   // Power-up lock time
  parameter int CHG_CYCLES = CHG_CYC      // Channel settle time
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  chsel_if.device LINK,
  output logic [7:0] CHANNEL_O,   // Active channel
  output logic LOAD_ERR_O,         // Last load failed
  output logic READY_O             // Locked, data may be sent
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DS_IDLE, DS_SHIFT, DS_LATCH
  } dstate_t;

  typedef struct packed {
    logic [1:0] clk_s1;     // Clock synchroniser stages 1 and 2
    logic [1:0] clk_s2;     // Stage 3 and previous
    logic [1:0] dat_s;      // Data synchroniser
    logic [1:0] mode_s;     // Mode synchroniser
    logic [5:0] par_s;      // Parallel pins, two stages
    dstate_t st;            // Receiver state
    logic [7:0] shreg;      // Shift register
    logic [3:0] nbits;      // Bits received
    logic [31:0] tmr;       // Phase timer
    logic bad;              // Timing violation seen
    logic [7:0] chan;       // Selected channel
    logic [7:0] prev_chan;  // For change detect
    logic err;              // Error flag
    logic started;          // Power-up default applied
    logic [31:0] settle;    // Lock / settle counter
    logic ready;            // Ready output
  } dev_t;

  dev_t r;
  dev_t next_r;

  // Parallel channel map: three pins pick entries from serial table
  function automatic logic [7:0] par_chan(input logic [2:0] p);
    case (p)
      3'h0: par_chan = 8'h02;
      3'h1: par_chan = 8'h0E;
      3'h2: par_chan = 8'h14;
      3'h3: par_chan = 8'h1A;
      3'h4: par_chan = 8'h26;
      3'h5: par_chan = 8'h32;
      3'h6: par_chan = 8'h44;
      default: par_chan = 8'h4A;
    endcase
  endfunction

  logic rise;
  logic fall;
  logic clk_now;
  logic dat_now;
  logic mode_now;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    // Synchronisers on every pin: two flops, three on the clock
    next_r.clk_s1 = {r.clk_s1[0], LINK.serial_clock_line};
    next_r.clk_s2 = {r.clk_s2[0], r.clk_s1[1]};
    next_r.dat_s = {r.dat_s[0], LINK.serial_data_line};
    next_r.mode_s = {r.mode_s[0], LINK.mode_line};
    next_r.par_s = {r.par_s[2:0], LINK.serial_data_line,
      LINK.serial_clock_line, LINK.parallel_select_bit0};
    clk_now = r.clk_s2[0];
    dat_now = r.dat_s[1];
    mode_now = r.mode_s[1];
    rise = r.clk_s2[0] && !r.clk_s2[1];
    fall = !r.clk_s2[0] && r.clk_s2[1];
    // Phase timer saturates, never times out
    if (r.tmr != 32'hFFFF_FFFF) begin
      next_r.tmr = r.tmr + 32'h1;
    end
    if (rise || fall) begin
      next_r.tmr = 32'h0;
    end
    if (!mode_now) begin
      // Parallel mode: pins pick channel directly
      next_r.chan = par_chan(r.par_s[5:3]);
      next_r.st = DS_IDLE;
      next_r.started = 1'b1;
    end else begin
      if (!r.started) begin
        next_r.chan = CH_DEFAULT;
        next_r.started = 1'b1;
      end
      case (r.st)
        DS_IDLE: begin
          // Clock falling with data low opens a packet
          if (fall && !dat_now) begin
            next_r.st = DS_SHIFT;
            next_r.nbits = 4'h0;
            next_r.bad = 1'b0;
          end
        end
        DS_SHIFT: begin
          if (fall && r.tmr < 32'(CLK_HI_CYC - 2)) begin
            next_r.bad = 1'b1;
          end
          if (rise && r.tmr < 32'(CLK_LO_CYC - 2)) begin
            next_r.bad = 1'b1;
          end
          // Sample data on rising clock, MSB first
          if (rise && r.nbits < 4'(NUM_BITS)) begin
            next_r.shreg = {r.shreg[6:0], dat_now};
            next_r.nbits = r.nbits + 4'h1;
          end
          // Both high after eighth bit: latch condition
          if (r.nbits == 4'(NUM_BITS) && clk_now && dat_now) begin
            next_r.st = DS_LATCH;
          end
          if (fall && r.nbits == 4'(NUM_BITS)) begin
            next_r.bad = 1'b1;
          end
        end
        DS_LATCH: begin
          // Commit once clock and data lines have both stayed high
          if (!clk_now || !dat_now) begin
            next_r.st = DS_IDLE;
          end else if (r.tmr >= 32'(LATCH_CYC - 2)) begin
            next_r.st = DS_IDLE;
            if (r.bad || r.shreg > CH_MAX) begin
              next_r.chan = CH_ERROR;
              next_r.err = 1'b1;
            end else begin
              next_r.chan = r.shreg;
              next_r.err = 1'b0;
            end
          end
        end
        default: next_r.st = DS_IDLE;
      endcase
    end
    // Ready after lock; channel change restarts settle
    if (r.chan != r.prev_chan && r.started) begin
      next_r.settle = 32'(CHG_CYCLES);
      next_r.ready = 1'b0;
    end else if (r.settle != 32'h0) begin
      next_r.settle = r.settle - 32'h1;
    end else begin
      next_r.ready = 1'b1;
    end
    next_r.prev_chan = r.chan;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r <= '0;
      r.mode_s <= 2'h3;
      r.settle <= 32'(LOCK_CYCLES);
    end else begin
      r <= next_r;
    end
  end

  // Mode sampled every cycle; grounded mode takes the parallel map
  assign CHANNEL_O = r.chan;
  assign LOAD_ERR_O = r.err;
  assign READY_O = r.ready;
endmodule

// *** common/chsel_pkg.sv ***
package chsel_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;              // System clock rate
  localparam int CLK_HI_NS = 8000;           // Least clock-high time
  localparam int CLK_LO_NS = 5000;           // Least clock-low time
  localparam int LATCH_NS = 5000;            // Least latch hold time
  localparam int PACKET_NS = 157000;         // Least packet time
  localparam int IDLE_NS = 10000;            // Idle gap between packets
  localparam int START_NS = 5000;            // Start step length
  localparam int LOCK_NS = 10000000;         // Power-up lock time
  localparam int CHG_NS = 1500000;           // Channel change time
  // Least times round up, longest times round down
  localparam int CLK_HI_CYC = (CLK_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int CLK_LO_CYC = (CLK_LO_NS * CLK_MHZ + 999) / 1000;
  localparam int LATCH_CYC = (LATCH_NS * CLK_MHZ + 999) / 1000;
  localparam int PACKET_CYC = (PACKET_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYC = (IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int START_CYC = (START_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYC = LOCK_NS / 1000 * CLK_MHZ;
  localparam int CHG_CYC = CHG_NS / 1000 * CLK_MHZ;
  // ---------------------------------------------------------------
  // Channel values
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_DEFAULT = 8'h32;  // Power-up channel
  localparam logic [7:0] CH_ERROR = 8'h00;    // Fallback on bad load
  localparam logic [7:0] CH_MAX = 8'h64;      // Highest serial channel
  localparam int NUM_BITS = 8;                // Bits per packet
  // ---------------------------------------------------------------
  // Host APB register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;    // W: channel, go bit 8
  localparam logic [3:0] REG_STATUS = 4'h4;  // R: busy, done count
  localparam int CTRL_GO_BIT = 8;            // Start a load
  localparam int STAT_BUSY_BIT = 0;          // Load in progress
endpackage

// *** common/chsel_if.sv ***
interface chsel_if;
  // ---------------------------------------------------------------
  // Select pins driven by host, mode strap
  // ---------------------------------------------------------------
  logic serial_clock_line;  // Select pin 1, serial clock
  logic serial_data_line;   // Select pin 2, serial data
  logic parallel_select_bit0;  // Select pin 0, parallel only
  logic mode_line;          // High or open: serial mode
  modport device (input serial_clock_line, serial_data_line,
    parallel_select_bit0, mode_line);
  modport host (output serial_clock_line, serial_data_line,
    parallel_select_bit0, mode_line);
endinterface

// *** rtl/chsel_host.sv ***
module chsel_host
  import chsel_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  chsel_if.host LINK,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [3:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SERIAL_MODE_I   // Drives the mode strap
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE, HS_GAP, HS_START, HS_LOW, HS_HIGH, HS_LATCH, HS_TAIL
  } hstate_t;

  typedef struct packed {
    hstate_t st;          // Sequencer state
    logic [7:0] chan;     // Channel being sent
    logic [3:0] nbits;    // Bits sent
    logic [31:0] tmr;     // Phase timer
    logic [31:0] pkt;     // Packet length counter
    logic sclk;           // Clock line
    logic sdat;           // Data line
    logic [15:0] done;    // Completed loads
    logic [31:0] rdata;   // Read data
  } host_t;

  host_t r;
  host_t next_r;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.tmr = r.tmr + 32'h1;
    next_r.pkt = r.pkt + 32'h1;
    // APB access, one wait-free access phase
    if (PSEL_I && PENABLE_I) begin
      if (PWRITE_I && PADDR_I == REG_CTRL && PWDATA_I[CTRL_GO_BIT]
          && r.st == HS_IDLE) begin
        next_r.chan = PWDATA_I[7:0];
        next_r.st = HS_GAP;
        next_r.tmr = 32'h0;
      end
    end
    // Read data taken in setup, so it stands through the access phase
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      next_r.rdata = (PADDR_I == REG_STATUS) ?
        {r.done, 15'h0, (r.st != HS_IDLE)} :
        (PADDR_I == REG_CTRL) ? {24'h0, r.chan} : 32'h0;
    end
    case (r.st)
      HS_IDLE: begin
        next_r.sclk = 1'b1;
        next_r.sdat = 1'b1;
      end
      HS_GAP: if (r.tmr >= 32'(IDLE_CYC)) begin
        // Data low, clock high opens packet
        next_r.sdat = 1'b0;
        next_r.st = HS_START;
        next_r.tmr = 32'h0;
        next_r.pkt = 32'h0;
      end
      HS_START: if (r.tmr >= 32'(START_CYC)) begin
        // Clock falls after data; data stays low a while longer
        next_r.sclk = 1'b0;
        next_r.st = HS_LOW;
        next_r.tmr = 32'h0;
        next_r.nbits = 4'h0;
      end
      HS_LOW: begin
        // Next bit goes out half way through the low phase
        if (r.tmr == 32'(CLK_LO_CYC / 2)) begin
          next_r.sdat = r.chan[3'(7 - r.nbits)];
        end
        if (r.tmr >= 32'(CLK_LO_CYC)) begin
          next_r.sclk = 1'b1;
          next_r.st = HS_HIGH;
          next_r.tmr = 32'h0;
          next_r.nbits = r.nbits + 4'h1;
        end
      end
      HS_HIGH: if (r.tmr >= 32'(CLK_HI_CYC)) begin
        next_r.tmr = 32'h0;
        if (r.nbits == 4'(NUM_BITS)) begin
          next_r.sdat = 1'b1;
          next_r.st = HS_LATCH;
        end else begin
          next_r.sclk = 1'b0;
          next_r.st = HS_LOW;
        end
      end
      HS_LATCH: if (r.tmr >= 32'(LATCH_CYC)) begin
        next_r.st = HS_TAIL;
      end
      HS_TAIL: if (r.pkt >= 32'(PACKET_CYC)) begin
        next_r.st = HS_IDLE;
        next_r.done = r.done + 16'h1;
      end
      default: next_r.st = HS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r <= '0;
      r.sclk <= 1'b1;
      r.sdat <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.serial_clock_line = r.sclk;
  assign LINK.serial_data_line = r.sdat;
  assign LINK.parallel_select_bit0 = 1'b0;
  assign LINK.mode_line = SERIAL_MODE_I;
  assign PRDATA_O = r.rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
endmodule

// *** tb/chsel_sva.sv ***
module chsel_checker
  import chsel_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic serial_clock_line,
  input wire logic serial_data_line,
  input wire logic mode_line,
  input wire logic [7:0] CHANNEL_O,
  input wire logic LOAD_ERR_O,
  input wire logic READY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Phase counters on the clock line
  // ---------------------------------------------------------------
  localparam int LIM = 1000;  // Longest wait for ready
  int hi_cnt;  // Cycles clock line seen high
  int lo_cnt;  // Cycles clock line seen low

  // Count the length of the current clock phase
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hi_cnt <= 0;
      lo_cnt <= 0;
    end else begin
      hi_cnt <= serial_clock_line ? hi_cnt + 1 : 0;
      lo_cnt <= serial_clock_line ? 0 : lo_cnt + 1;
    end
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_clk_high;
    $fell(serial_clock_line) |-> hi_cnt >= CLK_HI_CYC;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("clock high phase too short");
  property p_clk_low;
    $rose(serial_clock_line) |-> lo_cnt >= CLK_LO_CYC;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("clock low phase too short");
  property p_default;
    $rose(NRST_I) && mode_line |=> CHANNEL_O == CH_DEFAULT;
  endproperty
  a_default: assert property (p_default)
    else $error("power-up channel wrong");
  property p_lock;
    $rose(NRST_I) |-> ##[1:LIM] READY_O;
  endproperty
  a_lock: assert property (p_lock)
    else $error("ready late after reset");
  property p_range;
    CHANNEL_O <= CH_MAX;
  endproperty
  a_range: assert property (p_range)
    else $error("channel above highest");
  property p_err;
    $rose(LOAD_ERR_O) |-> ##[0:2] CHANNEL_O == CH_ERROR;
  endproperty
  a_err: assert property (p_err)
    else $error("failed load not on fallback channel");
  property p_latch;
    $changed(CHANNEL_O) && mode_line && !LOAD_ERR_O
      |-> serial_clock_line && serial_data_line;
  endproperty
  a_latch: assert property (p_latch)
    else $error("channel changed without latch condition");
  property p_ready_drop;
    $changed(CHANNEL_O) |-> ##[0:2] !READY_O;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready kept during channel change");
  property p_ready_back;
    $fell(READY_O) |-> ##[1:LIM] READY_O;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready late after channel change");

  // Main scenarios reached
  c_err: cover property ($rose(LOAD_ERR_O));
  c_settle: cover property ($fell(READY_O));
  c_start: cover property ($fell(serial_data_line) && serial_clock_line);
endmodule

// *** tb/testbench.sv ***
module testbench
  import chsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, serial_mode;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] channel, ch_a;
  logic load_err, ready, clk_seen;
  logic [8:0] cap;  // Last nine bits seen on clock rises
  int rises;  // Clock line rises seen
  int fail_count, check_count, n;
  int seed = 32'hB77C3ADC;
  chsel_if lnk();
  chsel_host u_chsel_host (.CLK_I(clk), .NRST_I(rst_n), .LINK(lnk.host),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SERIAL_MODE_I(serial_mode));
  chsel_device #(.LOCK_CYCLES(100), .CHG_CYCLES(100)) u_chsel_device (
    .CLK_I(clk), .NRST_I(rst_n), .LINK(lnk.device), .CHANNEL_O(channel),
    .LOAD_ERR_O(load_err), .READY_O(ready));
  chsel_checker u_chsel_checker (.CLK_I(clk), .NRST_I(rst_n),
    .serial_clock_line(lnk.serial_clock_line),
    .serial_data_line(lnk.serial_data_line), .mode_line(lnk.mode_line),
    .CHANNEL_O(channel), .LOAD_ERR_O(load_err), .READY_O(ready));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Sample the data line on each clock line rise
  always @(posedge clk) begin
    clk_seen <= lnk.serial_clock_line;
    if (lnk.serial_clock_line === 1'b1 && clk_seen === 1'b0) begin
      cap <= {cap[7:0], lnk.serial_data_line};
      rises <= rises + 1;
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask

  // One APB transfer; read data is taken at the ready edge
  task automatic apb(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full channel load with a second go while busy
  task automatic load(input logic [7:0] ch);
    logic [31:0] st, q;
    int r0, k;
    r0 = rises;
    apb(1'b0, REG_STATUS, 32'h0, st);
    apb(1'b1, REG_CTRL, {23'h0, 1'b1, ch}, q);
    apb(1'b0, REG_STATUS, 32'h0, q);
    check(32'(q[STAT_BUSY_BIT]), 32'h1, "busy after go");
    apb(1'b1, REG_CTRL, {23'h0, 1'b1, ~ch}, q);
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, q);
      k++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && k < 20000);
    check(32'(q[31:16]), 32'(st[31:16] + 16'h1), "done count");
    k = 0;
    while (channel !== (ch > CH_MAX ? CH_ERROR : ch) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check(32'(channel), 32'(ch > CH_MAX ? CH_ERROR : ch), "channel");
    check(32'(load_err), 32'(ch > CH_MAX), "load error flag");
    check(32'(cap[7:0]), 32'(ch), "wire bits");
    check(32'(rises - r0), 32'(NUM_BITS), "clock rises per packet");
    k = 0;
    while (ready !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    check(32'(ready), 32'h1, "ready after load");
    $display("load of %0d finished", ch);
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h0;
    serial_mode = 1'b1;
    rises = 0;
    cap = 9'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(32'(channel), 32'(CH_DEFAULT), "power-up channel");
    n = 0;
    while (ready !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check(32'(ready), 32'h1, "ready after reset");
    apb(1'b0, 4'h8, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    check(32'(pslverr), 32'h0, "slave error flag");
    $display("reset test finished");
    // Grounded mode: idle pins read 1,1,0, entry six of the map
    serial_mode <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(channel), 32'h44, "parallel channel");
    serial_mode <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'(channel), 32'h44, "channel kept on return");
    $display("mode test finished");
    ch_a = 8'($unsigned($random(seed)) % 101);
    load(ch_a);
    load(8'h65);
    results();
  end

  // Cut a hang short
  initial begin
    #390000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule
